// File: core_aux_control_regs.vh
// register map, field positions and reset values of the core auxiliary control block
`ifndef CORE_AUX_CONTROL_REGS_VH
`define CORE_AUX_CONTROL_REGS_VH
// register indices as printed; byte address is four times the index
`define IDX_AUX_STROBE_CONTROL 8'h8e
`define IDX_AUX_POINTER_SELECT 8'ha2
`define IDX_INTERRUPT_ENABLE 8'ha8
// own registers for the selected pointer bytes, the pointer operations and the irq status
`define IDX_POINTER_LOW 8'h82
`define IDX_POINTER_HIGH 8'h83
`define IDX_POINTER_CMD 8'hb0
`define IDX_POINTER_LOAD 8'hb1
`define IDX_IRQ_STATUS 8'hb2
`define IDX_EXT_ADDRESS 8'hb3
// interrupt enable fields
`define IE_GLOBAL 7
`define IE_RESERVED 6
`define IE_SOURCES 6
// auxiliary register fields
`define STROBE_OFF_BIT 0
`define PTR_SELECT_BIT 0
`define ZERO_BIT 2
`define USER_FLAG_BIT 3
// pointer command codes in the command register
`define CMD_INCREMENT 2'h1
`define CMD_INC_AUX 2'h2
// reset values and strobe counter wrap point
`define IE_RESET 8'h00
`define AUX_RESET 8'h00
`define PTR_RESET 16'h0000
`define STROBE_PERIOD 4'h5
`endif

// File: core_aux_control.v
// apb register logic for interrupt enables, strobe suppression and dual data pointer
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "core_aux_control_regs.vh"
// Functional notes
// - global enable clear blocks every interrupt source regardless of individual enables
// - with global enable set each source follows its own enable bit
// - six source enables at bits 5..0, one enables, zero disables
// - strobe-off bit stops pulses on the address latch strobe output
// - two independent 16-bit data pointers chosen by one select bit
// - select bit at bit 0 of pointer-select register, 0 pointer zero, 1 pointer one
// - bit 2 of pointer-select register ignores writes and reads zero
// - incrementing pointer-select register toggles select, leaves user flag intact
// - bit 3 of pointer-select register is a plain software flag
// - every pointer operation uses the currently selected pointer
// - pointer increment adds one to the full 16-bit selected pointer
// - immediate load writes a 16-bit constant into selected pointer
// - external data access presents selected pointer as 16-bit address
// - selected pointer low and high bytes are individually readable and writable
module core_aux_control
(
    // apb slave side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // interrupt requests in, gated requests out
    input wire [5:0] irq_request,
    output reg [5:0] irq_pass,
    // external bus side
    output reg addr_strobe,
    output reg [15:0] ext_address
);

////////////////////////////////////////////////////////////////////////////////
// state

// architectural registers
reg [7:0] interrupt_enable_reg;
reg [7:0] aux_strobe_control_reg;
reg [7:0] aux_pointer_select_reg;
reg [15:0] pointer_zero_reg;
reg [15:0] pointer_one_reg;
// strobe counter and interrupt synchroniser
reg [3:0] strobe_count_reg;
reg [5:0] irq_sync1_reg;
reg [5:0] irq_sync2_reg;

// decoded bus phases, pointer selection and strobe timing
wire [9:0] word_index;
wire wr_access;
wire setup_phase;
wire rd_setup;
wire wr_commit;
wire pointer_select;
wire [15:0] data_pointer;
wire addr_hit;
wire strobe_wrap;
wire strobe_slot;
reg [31:0] read_value;

// byte address to register index; the two low address bits are ignored
assign word_index = paddr[11:2];
assign wr_access = psel & penable & pwrite;
// setup phase: the answer is prepared here so that it stands in the access phase
assign setup_phase = psel & ~penable;
assign rd_setup = setup_phase & ~pwrite;
// a write lands only in the access phase that is being acknowledged
assign wr_commit = wr_access & pready;
// wrap point and pulse slot of the strobe counter
assign strobe_wrap = (strobe_count_reg == `STROBE_PERIOD);
assign strobe_slot = (strobe_count_reg == 4'h0);
assign pointer_select = aux_pointer_select_reg[`PTR_SELECT_BIT];
assign data_pointer = pointer_select ? pointer_one_reg : pointer_zero_reg;

// true when the index names an implemented register
function is_mapped;
    input [9:0] idx;
    begin
        is_mapped = (idx == {2'h0, `IDX_AUX_STROBE_CONTROL}) ||
            (idx == {2'h0, `IDX_AUX_POINTER_SELECT}) ||
            (idx == {2'h0, `IDX_INTERRUPT_ENABLE}) ||
            (idx == {2'h0, `IDX_POINTER_LOW}) ||
            (idx == {2'h0, `IDX_POINTER_HIGH}) ||
            (idx == {2'h0, `IDX_POINTER_CMD}) ||
            (idx == {2'h0, `IDX_POINTER_LOAD}) ||
            (idx == {2'h0, `IDX_IRQ_STATUS}) ||
            (idx == {2'h0, `IDX_EXT_ADDRESS});
    end
endfunction

// compare the decoded index against one register
function hit;
    input [9:0] idx;
    input [7:0] reg_idx;
    begin
        hit = (idx == {2'h0, reg_idx});
    end
endfunction

// select-register write value: bit 2 forced low, unused bits low
function [7:0] aux_sel_mask;
    input [7:0] value;
    begin
        aux_sel_mask = {4'h0, value[`USER_FLAG_BIT], 1'b0, 1'b0, value[`PTR_SELECT_BIT]};
    end
endfunction

// interrupt enable value with the unimplemented bit cleared
function [7:0] ie_mask;
    input [7:0] value;
    begin
        ie_mask = value & ~(8'h01 << `IE_RESERVED);
    end
endfunction

assign addr_hit = is_mapped(word_index);

////////////////////////////////////////////////////////////////////////////////
// read multiplexer; write-only and unmapped indices read as zero

always @*
begin
    read_value = 32'h00000000;
    if (hit(word_index, `IDX_INTERRUPT_ENABLE))
        read_value = {24'h0, ie_mask(interrupt_enable_reg)};
    else if (hit(word_index, `IDX_AUX_STROBE_CONTROL))
        read_value = {24'h0, aux_strobe_control_reg};
    else if (hit(word_index, `IDX_AUX_POINTER_SELECT))
        read_value = {24'h0, aux_pointer_select_reg};
    else if (hit(word_index, `IDX_POINTER_LOW))
        read_value = {24'h0, data_pointer[7:0]};
    else if (hit(word_index, `IDX_POINTER_HIGH))
        read_value = {24'h0, data_pointer[15:8]};
    else if (hit(word_index, `IDX_POINTER_LOAD))
        read_value = {16'h0, data_pointer};
    else if (hit(word_index, `IDX_IRQ_STATUS))
        read_value = {26'h0, irq_pass};
    else if (hit(word_index, `IDX_EXT_ADDRESS))
        read_value = {16'h0, ext_address};
end

////////////////////////////////////////////////////////////////////////////////
// apb handshake: zero wait states, unmapped addresses answer with pslverr

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= setup_phase;
        pslverr <= setup_phase & ~addr_hit;
        // cleared outside the access phase so that a stale word never stands
        prdata <= 32'h00000000;
        if (rd_setup)
            prdata <= read_value;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers; writes take effect in the access phase

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        interrupt_enable_reg <= `IE_RESET;
        aux_strobe_control_reg <= `AUX_RESET;
        aux_pointer_select_reg <= `AUX_RESET;
    end
    else if (wr_commit)
    begin
        if (hit(word_index, `IDX_INTERRUPT_ENABLE))
            interrupt_enable_reg <= ie_mask(pwdata[7:0]);
        if (hit(word_index, `IDX_AUX_STROBE_CONTROL))
            aux_strobe_control_reg <= pwdata[7:0];
        // only the select bit and the user flag take the written value
        if (hit(word_index, `IDX_AUX_POINTER_SELECT))
            aux_pointer_select_reg <= aux_sel_mask(pwdata[7:0]);
        if (hit(word_index, `IDX_POINTER_CMD) && (pwdata[1:0] == `CMD_INC_AUX))
            // plain increment; bit 1 is always zero so the carry stops there
            aux_pointer_select_reg <= aux_sel_mask(aux_pointer_select_reg + 8'h01);
    end
end

////////////////////////////////////////////////////////////////////////////////
// data pointers: only the selected one is ever touched
// the other pointer keeps its value, so software can park an address in it

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pointer_zero_reg <= `PTR_RESET;
        pointer_one_reg <= `PTR_RESET;
    end
    else if (wr_commit)
    begin
        if (hit(word_index, `IDX_POINTER_LOW))
        begin
            if (pointer_select)
                pointer_one_reg[7:0] <= pwdata[7:0];
            else
                pointer_zero_reg[7:0] <= pwdata[7:0];
        end
        if (hit(word_index, `IDX_POINTER_HIGH))
        begin
            if (pointer_select)
                pointer_one_reg[15:8] <= pwdata[7:0];
            else
                pointer_zero_reg[15:8] <= pwdata[7:0];
        end
        if (hit(word_index, `IDX_POINTER_LOAD))
        begin
            if (pointer_select)
                pointer_one_reg <= pwdata[15:0];
            else
                pointer_zero_reg <= pwdata[15:0];
        end
        if (hit(word_index, `IDX_POINTER_CMD) && (pwdata[1:0] == `CMD_INCREMENT))
        begin
            if (pointer_select)
                pointer_one_reg <= pointer_one_reg + 16'h0001;
            else
                pointer_zero_reg <= pointer_zero_reg + 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// external address follows the selected pointer one cycle later
// registered so the pin never glitches on a select change; costs one cycle

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        ext_address <= `PTR_RESET;
    else
        ext_address <= data_pointer;
end

////////////////////////////////////////////////////////////////////////////////
// interrupt gating; requests come from outside the domain, so sync first

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_sync1_reg <= 6'h00;
        irq_sync2_reg <= 6'h00;
        irq_pass <= 6'h00;
    end
    else
    begin
        // only the second stage feeds logic; the first may still be settling
        irq_sync1_reg <= irq_request;
        irq_sync2_reg <= irq_sync1_reg;
        if (interrupt_enable_reg[`IE_GLOBAL])
            irq_pass <= irq_sync2_reg & interrupt_enable_reg[`IE_SOURCES-1:0];
        else
            irq_pass <= 6'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// free-running strobe generator; strobe-off holds it low to cut emissions

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        strobe_count_reg <= 4'h0;
        addr_strobe <= 1'b0;
    end
    else
    begin
        // the counter keeps running while off, so pulses resume in their old slots
        if (strobe_wrap)
            strobe_count_reg <= 4'h0;
        else
            strobe_count_reg <= strobe_count_reg + 4'h1;
        if (aux_strobe_control_reg[`STROBE_OFF_BIT])
            addr_strobe <= 1'b0;
        else
            addr_strobe <= strobe_slot;
    end
end

endmodule
`default_nettype wire

// File: core_aux_control_assertions.sv
// checker for the core auxiliary control register block
`timescale 1ns/1ns
`default_nettype none
module core_aux_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] irq_request,
    input wire logic [5:0] irq_pass,
    input wire logic addr_strobe,
    input wire logic [15:0] ext_address
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed transfers and their register index
    wire wr = psel && penable && pready && pwrite;
    wire rd = psel && penable && pready && !pwrite;
    wire [9:0] ix = paddr[11:2];
    ////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_irq_follows_req: assert property ((irq_pass & ~$past(irq_request, 3)) == 6'h00)
        else $error("irq pass without request");
    a_global_blocks: assert property (wr && ix == 10'h0a8 && !pwdata[7] |=>
        ##1 irq_pass == 6'h00)
        else $error("irq passed with global off");
    a_strobe_stays_off: assert property (wr && ix == 10'h08e && pwdata[0] |=>
        ##1 !addr_strobe [*6])
        else $error("strobe while off");
    a_strobe_gap: assert property (addr_strobe |=> !addr_strobe [*5])
        else $error("strobe too soon");
    a_ext_load: assert property (wr && ix == 10'h0b1 |=>
        ##1 ({16'h0000, ext_address} == ($past(pwdata, 2) & 32'h0000ffff)))
        else $error("ext address not loaded value");
    a_select_zero_bits: assert property (rd && ix == 10'h0a2 |->
        (prdata & 32'hfffffff6) == 32'h0)
        else $error("select reg bits not zero");
    a_ie_bit6_zero: assert property (rd && ix == 10'h0a8 |-> !prdata[6])
        else $error("enable bit 6 set");
    c_cmd: cover property (wr && ix == 10'h0b0);
    c_strobe: cover property (addr_strobe);
    c_irq: cover property (irq_pass != 6'h00);
endmodule
bind core_aux_control core_aux_checker core_aux_checker_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_request, .irq_pass,
    .addr_strobe, .ext_address);
`default_nettype wire

// File: core_aux_control_bench.sv
// self-checking bench for the core auxiliary control register block
`timescale 1ns/1ns
`default_nettype none
`include "core_aux_control_regs.vh"
module core_aux_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] irq_request = 6'h3f;
    wire [31:0] prdata;
    wire pready, pslverr, addr_strobe;
    wire [5:0] irq_pass;
    wire [15:0] ext_address;
    logic [31:0] got;
    logic err;
    int mismatches = 0;
    int checks_done = 0;
    int i;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    core_aux_control core_aux_control_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_request, .irq_pass, .addr_strobe, .ext_address);
    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an edge passes after release so back-to-back calls never clash
    task xfer(input logic [7:0] ix, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait states are the slave's call; only the watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        got = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] ix, input logic [31:0] d);
        xfer(ix, 1'b1, d);
    endtask
    task rd(input logic [7:0] ix, input logic [31:0] exp);
        xfer(ix, 1'b0, 32'h0);
        check(got, exp);
    endtask
    task count_strobes;
        got = 32'h0;
        repeat (12)
        begin
            @(posedge pclk);
            got = got + {31'h0, addr_strobe};
        end
    endtask
    ////////////////////////////////////////
    task test_irq;
        wr(`IDX_INTERRUPT_ENABLE, 32'h3f);
        repeat (5) @(posedge pclk);
        rd(`IDX_IRQ_STATUS, 32'h0);
        wr(`IDX_INTERRUPT_ENABLE, 32'hff);
        rd(`IDX_INTERRUPT_ENABLE, 32'hbf);
        rd(`IDX_IRQ_STATUS, 32'h3f);
        for (i = 0; i < 6; i++)
        begin
            wr(`IDX_INTERRUPT_ENABLE, 32'h80 | (32'h1 << i));
            repeat (5) @(posedge pclk);
            rd(`IDX_IRQ_STATUS, 32'h1 << i);
        end
        irq_request <= 6'h15;
        wr(`IDX_INTERRUPT_ENABLE, 32'hbf);
        repeat (5) @(posedge pclk);
        rd(`IDX_IRQ_STATUS, 32'h15);
        check({26'h0, irq_pass}, 32'h15);
    endtask
    task test_strobe;
        wr(`IDX_AUX_STROBE_CONTROL, 32'h1);
        rd(`IDX_AUX_STROBE_CONTROL, 32'h1);
        count_strobes;
        check(got, 32'h0);
        wr(`IDX_AUX_STROBE_CONTROL, 32'h0);
        count_strobes;
        check(got, 32'h2);
    endtask
    // pointer one gets abcd, pointer zero 12ff; select toggled by increment
    task test_pointer;
        wr(`IDX_POINTER_LOAD, 32'h12ff);
        wr(`IDX_AUX_POINTER_SELECT, 32'hff);
        rd(`IDX_AUX_POINTER_SELECT, 32'h09);
        wr(`IDX_POINTER_LOAD, 32'habcd);
        rd(`IDX_POINTER_LOW, 32'hcd);
        rd(`IDX_POINTER_HIGH, 32'hab);
        wr(`IDX_POINTER_HIGH, 32'h5a);
        wr(`IDX_POINTER_CMD, {30'h0, `CMD_INCREMENT});
        rd(`IDX_POINTER_LOAD, 32'h5ace);
        wr(`IDX_POINTER_CMD, {30'h0, `CMD_INC_AUX});
        rd(`IDX_AUX_POINTER_SELECT, 32'h08);
        rd(`IDX_POINTER_LOAD, 32'h12ff);
        wr(`IDX_POINTER_CMD, {30'h0, `CMD_INCREMENT});
        // the address register follows the pointer one edge late
        @(posedge pclk);
        check({16'h0, ext_address}, 32'h1300);
        rd(`IDX_EXT_ADDRESS, 32'h1300);
        wr(`IDX_POINTER_CMD, {30'h0, `CMD_INC_AUX});
        rd(`IDX_AUX_POINTER_SELECT, 32'h09);
        rd(`IDX_POINTER_LOAD, 32'h5ace);
        rd(8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    // mid-run reset returns every register to zero
    task test_reset;
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IDX_INTERRUPT_ENABLE, 32'h0);
        rd(`IDX_AUX_POINTER_SELECT, 32'h0);
        rd(`IDX_POINTER_LOAD, 32'h0);
        rd(`IDX_AUX_STROBE_CONTROL, 32'h0);
    endtask
    ////////////////////////////////////////
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IDX_INTERRUPT_ENABLE, 32'h0);
        rd(`IDX_AUX_POINTER_SELECT, 32'h0);
        test_irq;
        test_strobe;
        test_pointer;
        test_reset;
        stop_test;
    end
    // watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #200000;
        mismatches++;
        stop_test;
    end
endmodule
`default_nettype wire
